//--- verilog/scm_pkg.sv
// Package of constants for the system clock mode controller
package scm_pkg;
  // Register byte offsets
  localparam logic [7:0] SCM_CTRL_OFS   = 8'h00;
  localparam logic [7:0] SCM_TBCTRL_OFS = 8'h04;
  localparam logic [7:0] SCM_STATUS_OFS = 8'h08;
  localparam logic [7:0] SCM_DIV_OFS    = 8'h0C;
  // Control register fields
  localparam int CTRL_MAIN_CLOCK_SOURCE_SELECT_BIT  = 0;
  localparam int CTRL_XEN_BIT    = 1;
  localparam int CTRL_SLOW_OSC_ENABLE_BIT   = 2;
  localparam int CTRL_HALT_BIT   = 3;
  localparam int CTRL_GATE_BIT   = 4;
  localparam int CTRL_STOP_BIT   = 5;
  localparam logic [5:0] CTRL_RESET = 6'h02;
  // Time base control fields
  localparam int TB_DV7_BIT    = 0;
  localparam int TB_RUN_BIT    = 1;
  localparam int TB_IEN_BIT    = 2;
  localparam int TB_SEL_LSB    = 3;
  localparam int TB_SEL_W      = 2;
  localparam logic [4:0] TB_RESET = 5'h00;
  // Divider structure
  localparam int PRESCALE_W  = 2;
  localparam int DIVIDER_W   = 21;
  localparam int STAGE7_IDX  = 6;
  localparam int STATES_PER_CYCLE = 4;
  // Stop warm-up default count
  localparam int WARMUP_CYCLES = 64;
  // Operating modes
  typedef enum logic [3:0] {
    MODE_FAST_RUN_SINGLE, MODE_CPU_HALT_SINGLE, MODE_DEEP_HALT_SINGLE,
    MODE_FAST_RUN_DUAL, MODE_CPU_HALT_DUAL, MODE_SLOWRUN_FAST_ON,
    MODE_SLOWRUN_FAST_OFF, MODE_SLOW_HALT_FAST_OFF, MODE_SLOW_HALT_FAST_ON,
    MODE_DEEP_HALT_DUAL, MODE_STOP, MODE_WARMUP
  } scm_mode_t;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- verilog/scm_controller.sv
// System clock mode controller with timing generator and AXI4-Lite registers
// Contract
// - Timing generator: 2-stage prescaler, 21-stage divider, main clock, machine cycle counter.
// - Prescaler and divider clear on reset, stop entry and stop release.
// - Stage-seven input chosen from mode, source select and stage7 select bit.
// - Slow run or slow halt feeds slow clock to stage seven.
// - Warm-up after stop from fast run feeds stage six into stage seven.
// - Machine cycle is four states, each one main clock period.
// - Single mode: only fast oscillator, slow pins are ports, four fast periods.
// - Reset enters single-clock fast run mode.
// - Halt request bit enters CPU halt; peripherals keep running.
// - Any interrupt request releases CPU halt to fast run.
// - On release, master enable one services interrupt, else continues.
// - Peripheral clock gate bit enters deep halt; only time base clocked.
// - Falling edge of selected time-base source ends deep halt.
// - Deep halt ignores run bit; wake interrupt needs enable, irq enable, run.
// - Deep halt entered with run set sets time-base interrupt latch on return.
// - Dual mode: both oscillators; main clock fast or slow by mode.
// - Device starts single mode; software enables slow oscillator for dual.
// - Dual fast run: CPU on fast clock, peripherals may use either.
// - Source select one goes slow-run fast-on; zero returns to dual fast run.
// - Clearing fast enable in slow-run fast-on stops fast oscillator.
// - Slow-run fast-off and slow halts stop stages one to six.
// - Dual CPU halt behaves like single halt, returning to dual fast run.
// - Slow halt fast-off keeps slow side, returns to slow-run fast-off.
`timescale 1ns/100ps
module scm_controller #(
  parameter int WARMUP = scm_pkg::WARMUP_CYCLES
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address and data
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Oscillator ticks, asynchronous
  input  wire logic        fast_osc_in,
  input  wire logic        slow_osc_in,
  // Wake sources and master interrupt enable
  input  wire logic        irq_request,
  input  wire logic        stop_release,
  input  wire logic        master_interrupt_enable,
  // Clock control outputs
  output logic             main_clock_tick,
  output logic [1:0]       machine_state,
  output logic             cpu_run,
  output logic             periph_clock_en,
  output logic             fast_osc_on,
  output logic             slow_osc_on,
  output logic             slow_pins_are_port,
  output logic             service_irq,
  output logic             time_base_interrupt,
  output logic [20:0]      divider_stages
);

  // Register state
  logic [5:0]  ctrl_reg;
  logic [4:0]  tb_reg;
  scm_pkg::scm_mode_t mode_reg, mode_next;
  logic        stop_from_fast_reg;
  logic        tb_run_at_entry_reg;
  logic [15:0] warm_cnt_reg;
  logic [1:0]  pre_reg;
  logic [20:0] div_reg;
  logic        phase_fast_reg;

  // Synchronisers for pin inputs
  logic [1:0] fast_s, slow_s, irq_s, stop_s;
  logic       fast_d, slow_d;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fast_s <= 2'h0;
      slow_s <= 2'h0;
      irq_s  <= 2'h0;
      stop_s <= 2'h0;
      fast_d <= 1'b0;
      slow_d <= 1'b0;
    end else begin
      fast_s <= {fast_s[0], fast_osc_in};
      slow_s <= {slow_s[0], slow_osc_in};
      irq_s  <= {irq_s[0], irq_request};
      stop_s <= {stop_s[0], stop_release};
      fast_d <= fast_s[1];
      slow_d <= slow_s[1];
    end
  end

  // Rising edges of the oscillator ticks
  logic fast_rise, slow_rise, irq_w, stop_w;
  assign fast_rise = fast_s[1] & ~fast_d;
  assign slow_rise = slow_s[1] & ~slow_d;
  assign irq_w  = irq_s[1];
  assign stop_w = stop_s[1];

  // Mode classes
  function automatic logic is_slow(input scm_pkg::scm_mode_t m);
    return m == scm_pkg::MODE_SLOWRUN_FAST_ON || m == scm_pkg::MODE_SLOWRUN_FAST_OFF ||
           m == scm_pkg::MODE_SLOW_HALT_FAST_OFF || m == scm_pkg::MODE_SLOW_HALT_FAST_ON ||
           m == scm_pkg::MODE_DEEP_HALT_DUAL;
  endfunction
  function automatic logic is_fast_off(input scm_pkg::scm_mode_t m);
    return m == scm_pkg::MODE_SLOWRUN_FAST_OFF || m == scm_pkg::MODE_SLOW_HALT_FAST_OFF ||
           m == scm_pkg::MODE_DEEP_HALT_DUAL || m == scm_pkg::MODE_STOP;
  endfunction

  // Bus write handshake
  logic wr_go, rd_go;
  logic aw_seen, w_seen;
  logic [7:0]  aw_hold;
  logic [31:0] w_hold;
  logic [3:0]  s_hold;
  assign wr_go = aw_seen & w_seen & ~s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_seen <= 1'b0;
      w_seen  <= 1'b0;
      aw_hold <= 8'h00;
      w_hold  <= 32'h0000_0000;
      s_hold  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_seen <= 1'b1;
        aw_hold <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_seen <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_seen <= 1'b1;
        w_hold <= s_axi_wdata;
        s_hold <= s_axi_wstrb;
      end else if (wr_go) begin
        w_seen <= 1'b0;
      end
    end
  end
  assign s_axi_awready = ~aw_seen;
  assign s_axi_wready  = ~w_seen;

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= scm_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_hold == scm_pkg::SCM_CTRL_OFS || aw_hold == scm_pkg::SCM_TBCTRL_OFS)
                      ? scm_pkg::RESP_OKAY : scm_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control register; halt, gate and stop bits self-clear on any mode change
  logic wr_ctrl, wr_tb;
  assign wr_ctrl = wr_go && aw_hold == scm_pkg::SCM_CTRL_OFS && s_hold[0];
  assign wr_tb   = wr_go && aw_hold == scm_pkg::SCM_TBCTRL_OFS && s_hold[0];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= scm_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= w_hold[5:0];
    end else begin
      if (mode_reg != mode_next) begin
        ctrl_reg[scm_pkg::CTRL_HALT_BIT] <= 1'b0;
        ctrl_reg[scm_pkg::CTRL_GATE_BIT] <= 1'b0;
        ctrl_reg[scm_pkg::CTRL_STOP_BIT] <= 1'b0;
      end
      // Leaving slow-run fast-off by wake restores nothing; fast enable follows mode
      if (mode_next == scm_pkg::MODE_FAST_RUN_SINGLE || mode_next == scm_pkg::MODE_FAST_RUN_DUAL)
        ctrl_reg[scm_pkg::CTRL_XEN_BIT] <= 1'b1;
    end
  end

  // Time base control register
  always_ff @(posedge aclk) begin
    if (!aresetn)
      tb_reg <= scm_pkg::TB_RESET;
    else if (wr_tb)
      tb_reg <= w_hold[4:0];
  end

  // Selected time-base source: stage chosen by select field, falling edge wakes
  logic [1:0] tb_sel;
  logic       tb_src, tb_src_d, tb_fall;
  assign tb_sel  = tb_reg[scm_pkg::TB_SEL_LSB +: scm_pkg::TB_SEL_W];
  assign tb_src  = div_reg[5'd8 + {1'b0, tb_sel, 2'b00}];
  assign tb_fall = tb_src_d & ~tb_src;
  always_ff @(posedge aclk) begin
    if (!aresetn)
      tb_src_d <= 1'b0;
    else
      tb_src_d <= tb_src;
  end

  // Mode transitions
  always_comb begin
    mode_next = mode_reg;
    unique case (mode_reg)
      scm_pkg::MODE_FAST_RUN_SINGLE, scm_pkg::MODE_FAST_RUN_DUAL: begin
        if (ctrl_reg[scm_pkg::CTRL_STOP_BIT])
          mode_next = scm_pkg::MODE_STOP;
        else if (ctrl_reg[scm_pkg::CTRL_GATE_BIT])
          mode_next = scm_pkg::MODE_DEEP_HALT_SINGLE;
        else if (ctrl_reg[scm_pkg::CTRL_HALT_BIT])
          mode_next = (mode_reg == scm_pkg::MODE_FAST_RUN_SINGLE) ?
                      scm_pkg::MODE_CPU_HALT_SINGLE : scm_pkg::MODE_CPU_HALT_DUAL;
        else if (ctrl_reg[scm_pkg::CTRL_MAIN_CLOCK_SOURCE_SELECT_BIT] && ctrl_reg[scm_pkg::CTRL_SLOW_OSC_ENABLE_BIT])
          mode_next = scm_pkg::MODE_SLOWRUN_FAST_ON;
        else
          mode_next = ctrl_reg[scm_pkg::CTRL_SLOW_OSC_ENABLE_BIT] ?
                      scm_pkg::MODE_FAST_RUN_DUAL : scm_pkg::MODE_FAST_RUN_SINGLE;
      end
      scm_pkg::MODE_CPU_HALT_SINGLE:
        if (irq_w) mode_next = scm_pkg::MODE_FAST_RUN_SINGLE;
      scm_pkg::MODE_CPU_HALT_DUAL:
        if (irq_w) mode_next = scm_pkg::MODE_FAST_RUN_DUAL;
      scm_pkg::MODE_DEEP_HALT_SINGLE:
        if (tb_fall) mode_next = scm_pkg::MODE_FAST_RUN_SINGLE;
      scm_pkg::MODE_SLOWRUN_FAST_ON: begin
        if (ctrl_reg[scm_pkg::CTRL_HALT_BIT])
          mode_next = scm_pkg::MODE_SLOW_HALT_FAST_ON;
        else if (!ctrl_reg[scm_pkg::CTRL_MAIN_CLOCK_SOURCE_SELECT_BIT])
          mode_next = scm_pkg::MODE_FAST_RUN_DUAL;
        else if (!ctrl_reg[scm_pkg::CTRL_XEN_BIT])
          mode_next = scm_pkg::MODE_SLOWRUN_FAST_OFF;
      end
      scm_pkg::MODE_SLOWRUN_FAST_OFF: begin
        if (ctrl_reg[scm_pkg::CTRL_STOP_BIT])
          mode_next = scm_pkg::MODE_STOP;
        else if (ctrl_reg[scm_pkg::CTRL_GATE_BIT])
          mode_next = scm_pkg::MODE_DEEP_HALT_DUAL;
        else if (ctrl_reg[scm_pkg::CTRL_HALT_BIT])
          mode_next = scm_pkg::MODE_SLOW_HALT_FAST_OFF;
        else if (ctrl_reg[scm_pkg::CTRL_XEN_BIT])
          mode_next = scm_pkg::MODE_SLOWRUN_FAST_ON;
      end
      scm_pkg::MODE_SLOW_HALT_FAST_OFF:
        if (irq_w) mode_next = scm_pkg::MODE_SLOWRUN_FAST_OFF;
      scm_pkg::MODE_SLOW_HALT_FAST_ON:
        if (irq_w) mode_next = scm_pkg::MODE_SLOWRUN_FAST_ON;
      scm_pkg::MODE_DEEP_HALT_DUAL:
        if (tb_fall) mode_next = scm_pkg::MODE_SLOWRUN_FAST_OFF;
      scm_pkg::MODE_STOP:
        if (stop_w) mode_next = scm_pkg::MODE_WARMUP;
      scm_pkg::MODE_WARMUP:
        if (warm_cnt_reg == 16'h0000)
          mode_next = stop_from_fast_reg ?
                      (ctrl_reg[scm_pkg::CTRL_SLOW_OSC_ENABLE_BIT] ? scm_pkg::MODE_FAST_RUN_DUAL
                                                        : scm_pkg::MODE_FAST_RUN_SINGLE)
                      : scm_pkg::MODE_SLOWRUN_FAST_OFF;
      default: mode_next = scm_pkg::MODE_FAST_RUN_SINGLE;
    endcase
  end

  // Mode register and entry bookkeeping
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg            <= scm_pkg::MODE_FAST_RUN_SINGLE;
      stop_from_fast_reg  <= 1'b0;
      tb_run_at_entry_reg <= 1'b0;
      warm_cnt_reg        <= 16'h0000;
    end else begin
      mode_reg <= mode_next;
      if (mode_next == scm_pkg::MODE_STOP && mode_reg != scm_pkg::MODE_STOP)
        stop_from_fast_reg <= !is_slow(mode_reg);
      if ((mode_next == scm_pkg::MODE_DEEP_HALT_SINGLE || mode_next == scm_pkg::MODE_DEEP_HALT_DUAL)
          && mode_next != mode_reg)
        tb_run_at_entry_reg <= tb_reg[scm_pkg::TB_RUN_BIT];
      if (mode_next == scm_pkg::MODE_WARMUP && mode_reg == scm_pkg::MODE_STOP)
        warm_cnt_reg <= 16'(WARMUP);
      else if (warm_cnt_reg != 16'h0000)
        warm_cnt_reg <= warm_cnt_reg - 16'h0001;
    end
  end

  // Wake events for interrupt latch and service decision
  logic deep_wake, halt_wake;
  assign deep_wake = (mode_reg == scm_pkg::MODE_DEEP_HALT_SINGLE || mode_reg == scm_pkg::MODE_DEEP_HALT_DUAL)
                     && mode_next != mode_reg;
  assign halt_wake = (mode_reg == scm_pkg::MODE_CPU_HALT_SINGLE || mode_reg == scm_pkg::MODE_CPU_HALT_DUAL ||
                      mode_reg == scm_pkg::MODE_SLOW_HALT_FAST_OFF || mode_reg == scm_pkg::MODE_SLOW_HALT_FAST_ON)
                     && mode_next != mode_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      time_base_interrupt <= 1'b0;
      service_irq         <= 1'b0;
    end else begin
      time_base_interrupt <= deep_wake && tb_run_at_entry_reg;
      service_irq <= (halt_wake && master_interrupt_enable) ||
                     (deep_wake && master_interrupt_enable && tb_reg[scm_pkg::TB_IEN_BIT] &&
                      tb_reg[scm_pkg::TB_RUN_BIT]);
    end
  end

  // Stage-seven input selection
  logic low_stop, stage7_in;
  assign low_stop = is_fast_off(mode_reg) || mode_reg == scm_pkg::MODE_SLOW_HALT_FAST_ON;
  always_comb begin
    if (mode_reg == scm_pkg::MODE_WARMUP && stop_from_fast_reg)
      stage7_in = div_reg[5] & ~div_reg[4] & (&div_reg[3:0]) & (&pre_reg) & fast_rise;
    else if (is_slow(mode_reg) || (tb_reg[scm_pkg::TB_DV7_BIT] && mode_reg != scm_pkg::MODE_STOP))
      stage7_in = slow_rise;
    else
      stage7_in = (&div_reg[5:0]) & (&pre_reg) & fast_rise;
  end

  // Prescaler and divider, with prescaler and first six stages stopped in slow modes except slow-run fast-on
  logic stop_edge;
  assign stop_edge = (mode_next == scm_pkg::MODE_STOP) != (mode_reg == scm_pkg::MODE_STOP);
  always_ff @(posedge aclk) begin
    if (!aresetn || stop_edge) begin
      pre_reg <= 2'h0;
      div_reg <= 21'h000000;
    end else if (mode_reg != scm_pkg::MODE_STOP) begin
      if (!low_stop && fast_rise) begin
        pre_reg <= pre_reg + 2'h1;
        if (&pre_reg)
          div_reg[5:0] <= div_reg[5:0] + 6'h01;
      end
      if (stage7_in)
        div_reg[20:6] <= div_reg[20:6] + 15'h0001;
    end
  end

  // Main clock tick chosen at a tick boundary of the current source
  logic use_slow;
  assign use_slow = is_slow(mode_reg);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_fast_reg  <= 1'b1;
      main_clock_tick <= 1'b0;
      machine_state   <= 2'h0;
    end else begin
      main_clock_tick <= 1'b0;
      if (mode_reg != scm_pkg::MODE_STOP && mode_reg != scm_pkg::MODE_WARMUP) begin
        if (phase_fast_reg ? fast_rise : slow_rise) begin
          main_clock_tick <= 1'b1;
          machine_state   <= machine_state + 2'h1;
          phase_fast_reg  <= ~use_slow;
        end
      end
    end
  end

  // Gating and oscillator outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_run            <= 1'b1;
      periph_clock_en    <= 1'b1;
      fast_osc_on        <= 1'b1;
      slow_osc_on        <= 1'b0;
      slow_pins_are_port <= 1'b1;
      divider_stages     <= 21'h000000;
    end else begin
      cpu_run <= mode_reg == scm_pkg::MODE_FAST_RUN_SINGLE || mode_reg == scm_pkg::MODE_FAST_RUN_DUAL ||
                 mode_reg == scm_pkg::MODE_SLOWRUN_FAST_ON || mode_reg == scm_pkg::MODE_SLOWRUN_FAST_OFF;
      periph_clock_en <= mode_reg != scm_pkg::MODE_DEEP_HALT_SINGLE && mode_reg != scm_pkg::MODE_DEEP_HALT_DUAL &&
                         mode_reg != scm_pkg::MODE_STOP && mode_reg != scm_pkg::MODE_WARMUP;
      fast_osc_on <= !is_fast_off(mode_reg);
      slow_osc_on <= ctrl_reg[scm_pkg::CTRL_SLOW_OSC_ENABLE_BIT] && mode_reg != scm_pkg::MODE_STOP;
      slow_pins_are_port <= !ctrl_reg[scm_pkg::CTRL_SLOW_OSC_ENABLE_BIT];
      divider_stages <= div_reg;
    end
  end

  // Read channel
  logic [31:0] rd_word;
  always_comb begin
    unique case (s_axi_araddr)
      scm_pkg::SCM_CTRL_OFS:   rd_word = {26'h0, ctrl_reg};
      scm_pkg::SCM_TBCTRL_OFS: rd_word = {27'h0, tb_reg};
      scm_pkg::SCM_STATUS_OFS: rd_word = {26'h0, machine_state, mode_reg};
      scm_pkg::SCM_DIV_OFS:    rd_word = {9'h0, div_reg, pre_reg};
      default:                 rd_word = 32'h0000_0000;
    endcase
  end
  assign rd_go = s_axi_arvalid & s_axi_arready;
  assign s_axi_arready = ~s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= scm_pkg::RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= (s_axi_araddr[7:4] == 4'h0 && s_axi_araddr[1:0] == 2'h0)
                      ? scm_pkg::RESP_OKAY : scm_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

//--- bench/scm_controller_asserts.sv
// Port-level assertions for the clock mode controller
`timescale 1ns/100ps
module scm_controller_asserts (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Interrupt enable input, mode and clock outputs
  input wire logic        master_interrupt_enable,
  input wire logic        main_clock_tick,
  input wire logic [1:0]  machine_state,
  input wire logic        cpu_run,
  input wire logic        periph_clock_en,
  input wire logic        fast_osc_on,
  input wire logic        slow_osc_on,
  input wire logic        slow_pins_are_port,
  input wire logic        service_irq,
  input wire logic        time_base_interrupt
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Both write channels taken at one edge
  sequence write_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Answer held until the master takes it
  sequence resp_waiting;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  a_write_answered: assert property (write_taken |=> ##1 s_axi_bvalid) else $error("write response late");
  a_resp_holds: assert property (resp_waiting |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("rdata dropped");
  a_reset_fast_run: assert property ($rose(aresetn) |-> cpu_run && periph_clock_en && fast_osc_on && !slow_osc_on)
    else $error("not in fast run after reset");
  a_state_steps: assert property ($changed(machine_state) |-> machine_state == $past(machine_state) + 2'h1)
    else $error("machine state skipped");
  a_tick_spacing: assert property (main_clock_tick |=> !main_clock_tick) else $error("tick too long");
  a_pins_follow_osc: assert property ($stable(slow_osc_on) |-> slow_pins_are_port == !slow_osc_on)
    else $error("slow pins wrong");
  a_gate_stops_cpu: assert property (!periph_clock_en |-> !cpu_run) else $error("cpu runs while gated");
  a_service_pulse: assert property (service_irq |-> $past(master_interrupt_enable) ##1 !service_irq)
    else $error("service pulse wrong");
  a_tbi_pulse: assert property (time_base_interrupt |=> !time_base_interrupt) else $error("latch pulse long");
  c_gate: cover property (!periph_clock_en ##1 periph_clock_en);
endmodule

bind scm_controller scm_controller_asserts scm_controller_asserts_i (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .master_interrupt_enable, .main_clock_tick,
  .machine_state, .cpu_run, .periph_clock_en, .fast_osc_on, .slow_osc_on, .slow_pins_are_port, .service_irq,
  .time_base_interrupt
);

//--- bench/scm_controller_test.sv
// Self-checking testbench for the clock mode controller
`timescale 1ns/100ps
module scm_controller_test;
  // Design inputs
  logic        aclk = 1'b0, aresetn = 1'b0, fast_osc_in = 1'b0, slow_osc_in = 1'b0;
  logic        irq_request = 1'b0, stop_release = 1'b0, master_interrupt_enable = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  // Design outputs
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, main_clock_tick;
  logic [1:0]  s_axi_bresp, s_axi_rresp, machine_state, resp;
  logic [31:0] s_axi_rdata, rd;
  logic        cpu_run, periph_clock_en, fast_osc_on, slow_osc_on, slow_pins_are_port;
  logic        service_irq, time_base_interrupt;
  logic [20:0] divider_stages;
  int          errors = 0, tests_run = 0, cycles = 0;

  scm_controller #(.WARMUP(4)) scm_controller_i (.*);

  always #5 aclk = ~aclk;

  // Oscillators run only while enabled; timeout guard
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (fast_osc_on === 1'b1 && cycles % 4 == 3) fast_osc_in <= ~fast_osc_in;
    if (slow_osc_on === 1'b1 && cycles % 16 == 15) slow_osc_in <= ~slow_osc_in;
    if (cycles == 60000) begin
      errors++;
      give_verdict();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task give_verdict();
    if (errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Write with independent release of address and data channels
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_done = 1'b0;
    logic w_done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic mode_is(input scm_pkg::scm_mode_t m);
    axi_read(scm_pkg::SCM_STATUS_OFS, rd, resp);
    check("mode", rd[3:0], m);
  endtask

  // Main clock ticks over 320 cycles lie within one of the expected count
  task automatic tick_rate(input int exp);
    int n = 0;
    repeat (320) begin
      @(posedge aclk);
      if (main_clock_tick) n++;
    end
    check("tick count", n >= exp - 1 && n <= exp + 1, 1);
  endtask

  task automatic test_reset_values();
    axi_read(scm_pkg::SCM_CTRL_OFS, rd, resp);
    check("ctrl reset", rd[5:0], scm_pkg::CTRL_RESET);
    axi_read(scm_pkg::SCM_TBCTRL_OFS, rd, resp);
    check("tb reset", rd[4:0], scm_pkg::TB_RESET);
    mode_is(scm_pkg::MODE_FAST_RUN_SINGLE);
    check("pins port", slow_pins_are_port, 1'b1);
    tick_rate(40);
  endtask

  task automatic test_bus_errors();
    axi_write(8'h10, 32'h1, resp);
    check("unmapped write", resp, scm_pkg::RESP_SLVERR);
    axi_write(scm_pkg::SCM_STATUS_OFS, 32'h3, resp);
    check("status write", resp, scm_pkg::RESP_SLVERR);
    axi_read(8'h02, rd, resp);
    check("misaligned data", rd, 32'h0000_0000);
    check("misaligned resp", resp, scm_pkg::RESP_SLVERR);
  endtask

  // CPU halt woken by interrupt, with and without master enable
  task automatic test_halt();
    logic svc;
    for (int m = 0; m < 2; m++) begin
      @(posedge aclk);
      master_interrupt_enable <= m[0];
      axi_write(scm_pkg::SCM_CTRL_OFS, 32'h0A, resp);
      check("halt cpu", {cpu_run, periph_clock_en}, 2'b01);
      mode_is(scm_pkg::MODE_CPU_HALT_SINGLE);
      irq_request <= 1'b1;
      svc = 1'b0;
      repeat (10) begin
        @(posedge aclk);
        svc |= service_irq;
      end
      irq_request <= 1'b0;
      check("service", svc, m[0]);
      check("woken", cpu_run, 1'b1);
      mode_is(scm_pkg::MODE_FAST_RUN_SINGLE);
    end
  endtask

  // Deep halt with time base running, woken by stage nine falling
  task automatic test_deep_halt();
    logic tbi = 1'b0;
    logic svc = 1'b0;
    int n = 0;
    @(posedge aclk);
    master_interrupt_enable <= 1'b1;
    axi_write(scm_pkg::SCM_TBCTRL_OFS, 32'h06, resp);
    axi_write(scm_pkg::SCM_CTRL_OFS, 32'h12, resp);
    check("deep gate", {cpu_run, periph_clock_en}, 2'b00);
    mode_is(scm_pkg::MODE_DEEP_HALT_SINGLE);
    while (n < 40) begin
      @(posedge aclk);
      tbi |= time_base_interrupt;
      svc |= service_irq;
      if (periph_clock_en) n++;
    end
    mode_is(scm_pkg::MODE_FAST_RUN_SINGLE);
    check("deep service", svc, 1'b1);
    check("tb latch", tbi, 1'b1);
  endtask

  // Dual clock path through both slow run modes and back
  task automatic test_dual();
    logic [31:0] div0;
    axi_write(scm_pkg::SCM_CTRL_OFS, 32'h06, resp);
    mode_is(scm_pkg::MODE_FAST_RUN_DUAL);
    check("dual osc", {slow_osc_on, slow_pins_are_port}, 2'b10);
    axi_write(scm_pkg::SCM_CTRL_OFS, 32'h07, resp);
    mode_is(scm_pkg::MODE_SLOWRUN_FAST_ON);
    tick_rate(10);
    axi_write(scm_pkg::SCM_CTRL_OFS, 32'h05, resp);
    mode_is(scm_pkg::MODE_SLOWRUN_FAST_OFF);
    check("fast off", fast_osc_on, 1'b0);
    axi_read(scm_pkg::SCM_DIV_OFS, div0, resp);
    repeat (64) @(posedge aclk);
    axi_read(scm_pkg::SCM_DIV_OFS, rd, resp);
    check("low stages", rd[7:2], div0[7:2]);
    check("low stage pins", divider_stages[5:0], div0[7:2]);
    axi_write(scm_pkg::SCM_CTRL_OFS, 32'h07, resp);
    mode_is(scm_pkg::MODE_SLOWRUN_FAST_ON);
    axi_write(scm_pkg::SCM_CTRL_OFS, 32'h06, resp);
    mode_is(scm_pkg::MODE_FAST_RUN_DUAL);
  endtask

  // Stop clears the divider; release runs the warm-up and returns to fast run
  task automatic test_stop();
    axi_write(scm_pkg::SCM_CTRL_OFS, 32'h22, resp);
    mode_is(scm_pkg::MODE_STOP);
    axi_read(scm_pkg::SCM_DIV_OFS, rd, resp);
    check("stop clear", rd, 32'h0000_0000);
    stop_release <= 1'b1;
    repeat (12) @(posedge aclk);
    stop_release <= 1'b0;
    mode_is(scm_pkg::MODE_FAST_RUN_SINGLE);
  endtask

  // Reset, then the scenarios in turn
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    test_reset_values();
    test_bus_errors();
    test_halt();
    test_deep_halt();
    test_dual();
    test_stop();
    give_verdict();
  end
endmodule
